// *** logic/ift_pkg.sv ***
// package: field layout, opcode classes, timing constants and decoded-instruction carrier
package ift_pkg;

  // ****************************************
  // program word layout
  // ****************************************
  localparam int WORD_W      = 24;      // one program word
  localparam int OPC_W       = 8;       // opcode portion
  localparam int OPC_LSB     = 16;      // opcode sits in the upper bits
  localparam int WORKING_REG_ZERO_W      = 4;       // sixteen working registers
  localparam int MODE_W      = 2;       // address modifier code
  localparam int FILE_W      = 13;      // file register address
  localparam int LIT_W       = 16;      // widest literal carried
  localparam int PADDR_W     = 23;      // program memory address
  localparam int CYC_W       = 2;       // cycle count width

  // operand field positions inside the low 16 bits
  localparam int BASE_LSB    = 12;      // base working register
  localparam int DST_LSB     = 8;       // destination working register
  localparam int DMODE_LSB   = 6;       // destination modifier
  localparam int SRC_LSB     = 2;       // source working register
  localparam int SMODE_LSB   = 0;       // source modifier
  localparam int FDEST_BIT   = 13;      // file op: result to working reg zero
  localparam int BIT4_LSB    = 12;      // bit selector literal
  localparam int BIND_BIT    = 11;      // bit selector taken from base reg
  localparam int BFILE_BIT   = 10;      // bit op works on a file register
  localparam int LMOV_LSB    = 4;       // literal of a literal move
  localparam int LMOV_W      = 12;      // literal move width
  localparam int LFILE_BIT   = 3;       // literal move aimed at file reg (unused dst)
  localparam int LAR_LSB     = 4;       // literal of literal arithmetic
  localparam int LAR_W       = 8;       // literal arithmetic width
  localparam int LSAME_BIT   = 3;       // destination equals base register
  localparam int TMODE_LSB   = 0;       // table access mode
  localparam int PADDR_LO_W  = 16;      // address bits in first word
  localparam int PADDR_HI_W  = 7;       // address bits in second word

  // ****************************************
  // opcode classes (opcode bits 7:5 pick category)
  // ****************************************
  localparam logic [2:0] GRP_CTRL0 = 3'h0;  // control, low half
  localparam logic [2:0] GRP_WORKING_REG_ZERO  = 3'h1;  // word/byte on working regs
  localparam logic [2:0] GRP_FILE  = 3'h2;  // word/byte on file regs
  localparam logic [2:0] GRP_BIT   = 3'h3;  // bit oriented
  localparam logic [2:0] GRP_LMOV  = 3'h4;  // literal move
  localparam logic [2:0] GRP_LAR   = 3'h5;  // literal arithmetic
  localparam logic [2:0] GRP_DSP   = 3'h6;  // signal processing
  localparam logic [2:0] GRP_CTRL1 = 3'h7;  // control, high half

  localparam logic [7:0] OP_NOP        = 8'h00;  // also second word alone
  localparam logic [7:0] OP_CALL_DW    = 8'h02;  // double-word call
  localparam logic [7:0] OP_GOTO_DW    = 8'h04;  // double-word goto
  localparam logic [7:0] OP_MOVD_DW    = 8'h06;  // double-word move
  localparam logic [7:0] OP_BRANCH     = 8'h08;  // branch_op, unconditional
  localparam logic [7:0] OP_BRANCH_CMP = 8'h09;  // branch_op, computed
  localparam logic [7:0] OP_CALL_IND   = 8'h0A;  // indirect call
  localparam logic [7:0] OP_GOTO_IND   = 8'h0B;  // indirect goto
  localparam logic [7:0] OP_TBL_RD     = 8'h0C;  // table read
  localparam logic [7:0] OP_TBL_WR     = 8'h0D;  // table write
  localparam logic [7:0] OP_RETURN     = 8'h0E;  // return
  localparam logic [7:0] OP_RETFI      = 8'h0F;  // return_from_interrupt_op
  localparam logic [7:0] OP_BR_COND    = 8'h10;  // conditional branch
  localparam logic [7:0] OP_SKIP_LO    = 8'hE0;  // skip family, first code
  localparam logic [7:0] OP_SKIP_HI    = 8'hE7;  // skip family, last code

  // ****************************************
  // timing
  // ****************************************
  localparam logic [CYC_W-1:0] CYC_ONE   = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TWO   = 2'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [4:0] {
    CAT_WORD = 5'h01,
    CAT_BIT  = 5'h02,
    CAT_LIT  = 5'h04,
    CAT_DSP  = 5'h08,
    CAT_CTRL = 5'h10
  } ift_cat_t;

  typedef struct packed {
    logic [OPC_W-1:0]   opcode;
    ift_cat_t           category;
    logic [WORKING_REG_ZERO_W-1:0]  base_operand_reg;
    logic [WORKING_REG_ZERO_W-1:0]  source_operand_reg;
    logic [WORKING_REG_ZERO_W-1:0]  dest_operand_reg;
    logic [MODE_W-1:0]  src_mode;
    logic [MODE_W-1:0]  dst_mode;
    logic               dest_valid;
    logic [FILE_W-1:0]  file_addr;
    logic               use_file;
    logic               to_working_reg_zero;
    logic [LIT_W-1:0]   literal;
    logic [WORKING_REG_ZERO_W-1:0]  bit_sel;
    logic               bit_indirect;
    logic [MODE_W-1:0]  table_mode;
    logic [PADDR_W-1:0] prog_addr;
    logic               is_double;
    logic               is_nop;
  } ift_dec_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic negative;
    logic overflow;
    logic sticky_zero;
  } ift_flags_t;

endpackage

// *** logic/ift_decoder.sv ***
// module: instruction word split, operand decode and cycle-count sequencing
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - 24-bit word, 8-bit opcode plus operand fields
// - exactly three opcodes occupy two words
// - double-word operands gathered from both words
// - second word has all-zero upper opcode bits
// - lone second word executes as no-operation
// - plain single-word instruction takes one cycle
// - taken test or PC change adds nop cycle
// - branch, indirect, table, return take two-three
// - taken skip: two, or three over double
// - every double-word instruction takes two cycles
// - five categories: word, bit, literal, dsp, control
// - working ops decode base, source, destination
// - file ops: address plus file/working-zero destination
// - bit ops: register and literal or indirect bit
// - literal move loads literal into register/file
// - literal arithmetic: base, literal, optional destination
// - control: program address or table mode
// - working register fields select sixteen registers
// - status flags: carry, digit, negative, overflow, zero
module ift_decoder
  import ift_pkg::*;
(
  input  wire logic                  clock,         // instruction clock
  input  wire logic                  rst_n,         // async reset, low active
  input  wire logic                  fetch_valid,   // program word offered
  input  wire logic [ift_pkg::WORD_W-1:0] fetch_word, // the offered word
  input  wire logic [ift_pkg::WORD_W-1:0] follow_word, // word after current one
  input  wire logic                  cond_true,     // datapath test result
  input  wire logic [4:0]            flags_raw,     // datapath flag results
  output logic                       fetch_ready,   // word will be taken
  output logic                       pc_step,       // advance pc one word
  output logic                       issue,         // decoded instruction out
  output ift_pkg::ift_dec_t          decoded,       // decoded fields
  output logic [ift_pkg::CYC_W-1:0]  cycles,        // cycles this instruction
  output logic [1:0]                 skip_words,    // words skipped over
  output logic                       nop_slot,      // extra cycle is a nop
  output ift_pkg::ift_flags_t        flags          // status flags named
);
  import ift_pkg::*;

  // ****************************************
  // sequencing state
  // ****************************************
  typedef enum logic [2:0] {
    ST_FIRST  = 3'h1,  // waiting for an instruction word
    ST_SECOND = 3'h2,  // waiting for the second word
    ST_STALL  = 3'h4   // spending nop cycles
  } ift_state_t;

  ift_state_t                 state;        // current phase
  logic [WORD_W-1:0]          first_word;   // held first word of a pair
  logic [CYC_W-1:0]           stall_left;   // nop cycles still to spend
  logic                       take;         // word accepted this cycle
  logic [OPC_W-1:0]           fetch_op;     // opcode of offered word
  logic [OPC_W-1:0]           follow_op;    // opcode of following word
  logic [CYC_W-1:0]           next_cycles;  // cycle count for offered word

  // ****************************************
  // functions
  // ****************************************
  // opcode portion of a word
  function automatic logic [OPC_W-1:0] opc_of(input logic [WORD_W-1:0] w);
    opc_of = w[OPC_LSB +: OPC_W];
  endfunction

  // the three two-word opcodes
  function automatic logic is_dw(input logic [OPC_W-1:0] op);
    is_dw = (op == OP_CALL_DW) || (op == OP_GOTO_DW) || (op == OP_MOVD_DW);
  endfunction

  // skip family
  function automatic logic is_skip(input logic [OPC_W-1:0] op);
    is_skip = (op >= OP_SKIP_LO) && (op <= OP_SKIP_HI);
  endfunction

  // single-word ops that always take an extra cycle
  function automatic logic is_fixed_multi(input logic [OPC_W-1:0] op);
    is_fixed_multi = (op >= OP_BRANCH) && (op <= OP_RETFI);
  endfunction

  // cycle count of an instruction
  function automatic logic [CYC_W-1:0] cycles_of(input logic [OPC_W-1:0] op,
                                                 input logic cond,
                                                 input logic follow_dw);
    if (is_dw(op))
      cycles_of = CYC_TWO;
    else if ((op == OP_RETURN) || (op == OP_RETFI))
      cycles_of = CYC_THREE;
    else if (is_fixed_multi(op))
      cycles_of = CYC_TWO;
    else if (is_skip(op) && cond)
      cycles_of = follow_dw ? CYC_THREE : CYC_TWO;
    else if ((op == OP_BR_COND) && cond)
      cycles_of = CYC_TWO;
    else
      cycles_of = CYC_ONE;
  endfunction

  // full operand decode from one or two words
  function automatic ift_dec_t decode(input logic [WORD_W-1:0] w0,
                                      input logic [WORD_W-1:0] w1,
                                      input logic dw);
    ift_dec_t d;
    logic [OPC_W-1:0] op;
    d  = '0;
    op = opc_of(w0);
    d.opcode             = op;
    d.is_double          = dw;
    d.is_nop             = (op == OP_NOP);
    d.base_operand_reg   = w0[BASE_LSB +: WORKING_REG_ZERO_W];
    d.dest_operand_reg   = w0[DST_LSB +: WORKING_REG_ZERO_W];
    d.source_operand_reg = w0[SRC_LSB +: WORKING_REG_ZERO_W];
    unique case (op[OPC_W-1 -: 3])
      GRP_WORKING_REG_ZERO:
      begin
        // base plain, source and destination with modifiers
        d.category   = CAT_WORD;
        d.dst_mode   = w0[DMODE_LSB +: MODE_W];
        d.src_mode   = w0[SMODE_LSB +: MODE_W];
        d.dest_valid = 1'b1;
      end
      GRP_FILE:
      begin
        // file address, result to same file or working reg zero
        d.category            = CAT_WORD;
        d.file_addr           = w0[FILE_W-1:0];
        d.use_file            = 1'b1;
        d.to_working_reg_zero = w0[FDEST_BIT];
      end
      GRP_BIT:
      begin
        // bit number literal or held in base register
        d.category     = CAT_BIT;
        d.bit_sel      = w0[BIT4_LSB +: WORKING_REG_ZERO_W];
        d.bit_indirect = w0[BIND_BIT];
        d.use_file     = w0[BFILE_BIT];
        d.file_addr    = w0[BFILE_BIT] ? FILE_W'(w0[BFILE_BIT-1:0]) : '0;
        d.src_mode     = w0[SMODE_LSB +: MODE_W];
      end
      GRP_LMOV:
      begin
        // literal into a working register or file register
        d.category   = CAT_LIT;
        d.literal    = {4'h0, w0[LMOV_LSB +: LMOV_W]};
        d.use_file   = w0[LFILE_BIT];
        d.dest_valid = !w0[LFILE_BIT];
        d.dest_operand_reg = WORKING_REG_ZERO_W'(w0[LFILE_BIT-1:0]);
      end
      GRP_LAR:
      begin
        // base and literal in, destination only if distinct
        d.category   = CAT_LIT;
        d.literal    = {8'h00, w0[LAR_LSB +: LAR_W]};
        d.dest_valid = !w0[LSAME_BIT];
        d.dest_operand_reg = w0[LSAME_BIT] ? w0[BASE_LSB +: WORKING_REG_ZERO_W]
                                           : WORKING_REG_ZERO_W'(w0[LSAME_BIT-1:0]);
      end
      GRP_DSP:
      begin
        d.category   = CAT_DSP;
        d.dest_valid = 1'b1;
      end
      default:
      begin
        // control: program address or table mode
        d.category = CAT_CTRL;
        if ((op == OP_TBL_RD) || (op == OP_TBL_WR))
          d.table_mode = w0[TMODE_LSB +: MODE_W];
        else if (dw)
          d.prog_addr = {w1[PADDR_HI_W-1:0], w0[PADDR_LO_W-1:0]};
        else
          d.prog_addr = {7'h00, w0[PADDR_LO_W-1:0]};
        if (op == OP_MOVD_DW)
        begin
          d.category   = CAT_WORD;
          d.literal    = w0[LIT_W-1:0];
          d.dest_operand_reg = w1[WORKING_REG_ZERO_W-1:0];
          d.dest_valid = 1'b1;
          d.prog_addr  = '0;
        end
      end
    endcase
    decode = d;
  endfunction

  // ****************************************
  // handshake and lookahead
  // ****************************************
  // ready only while expecting a word
  assign fetch_ready = (state == ST_FIRST) || (state == ST_SECOND);
  assign take        = fetch_valid && fetch_ready;
  assign pc_step     = take;
  assign nop_slot    = (state == ST_STALL);
  assign fetch_op    = opc_of(fetch_word);
  assign follow_op   = opc_of(follow_word);
  assign next_cycles = cycles_of(fetch_op, cond_true, is_dw(follow_op));
  // flag bits passed on by name
  assign flags       = ift_flags_t'(flags_raw);

  // ****************************************
  // phase sequencing
  // ****************************************
  // first word, second word, nop stall
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= ST_FIRST;
      stall_left <= '0;
    end
    else
    begin
      unique case (state)
        ST_FIRST:
        begin
          if (take && is_dw(fetch_op))
            state <= ST_SECOND;
          else if (take && (next_cycles != CYC_ONE))
          begin
            state      <= ST_STALL;
            stall_left <= next_cycles - CYC_ONE;
          end
        end
        ST_SECOND:
        begin
          // second word completes the pair in its own cycle
          if (take)
            state <= ST_FIRST;
        end
        ST_STALL:
        begin
          if (stall_left == CYC_ONE)
            state <= ST_FIRST;
          stall_left <= stall_left - CYC_ONE;
        end
        default:
          state <= ST_FIRST;
      endcase
    end
  end

  // ****************************************
  // word holding
  // ****************************************
  // keep first word while the second is fetched
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      first_word <= '0;
    else if (take && (state == ST_FIRST))
      first_word <= fetch_word;
  end

  // ****************************************
  // decode output
  // ****************************************
  // one-cycle issue with registered fields
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      issue      <= 1'b0;
      decoded    <= '0;
      cycles     <= CYC_ONE;
      skip_words <= 2'h0;
    end
    else
    begin
      issue <= 1'b0;
      if (take && (state == ST_SECOND))
      begin
        // pair complete: both words combined
        issue      <= 1'b1;
        decoded    <= decode(first_word, fetch_word, 1'b1);
        cycles     <= CYC_TWO;
        skip_words <= 2'h0;
      end
      else if (take && !is_dw(fetch_op))
      begin
        // lone zero-opcode word decodes as nop
        issue      <= 1'b1;
        decoded    <= decode(fetch_word, '0, 1'b0);
        cycles     <= next_cycles;
        skip_words <= (is_skip(fetch_op) && cond_true)
                      ? (is_dw(follow_op) ? 2'h2 : 2'h1) : 2'h0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_double_two_cyc: assert property (@(posedge clock) disable iff (!rst_n)
    (take && (state == ST_FIRST) && is_dw(fetch_op)) |=>
      (state == ST_SECOND) and (fetch_valid |=> (issue && cycles == CYC_TWO)))
    else $error("double-word instruction not issued as two cycles");

  chk_pc_two_words: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && decoded.is_double) |-> $past(pc_step) && $past(state == ST_SECOND))
    else $error("pc not stepped past both words");

  chk_lone_nop: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && decoded.opcode == OP_NOP) |-> decoded.is_nop && cycles == CYC_ONE)
    else $error("zero opcode word not a nop");

  chk_single_one_cyc: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && cycles == CYC_ONE) |-> fetch_ready && !nop_slot)
    else $error("single-cycle instruction stalled");

  chk_nop_two_cyc: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && !decoded.is_double && cycles == CYC_TWO) |-> nop_slot ##1 !nop_slot)
    else $error("two-cycle instruction lacks one nop slot");

  chk_nop_three_cyc: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && cycles == CYC_THREE) |-> nop_slot[*2] ##1 fetch_ready)
    else $error("three-cycle instruction lacks two nop slots");

  chk_fixed_multi: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && is_fixed_multi(decoded.opcode)) |-> cycles != CYC_ONE)
    else $error("branch, table or return took one cycle");

  chk_skip_count: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && skip_words != 2'h0) |-> (cycles == CYC_ONE + skip_words))
    else $error("skip cycle count mismatch");

  chk_category_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    issue |-> $onehot(decoded.category))
    else $error("category not one of five");

  chk_file_dest: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && decoded.opcode[OPC_W-1 -: 3] == GRP_FILE) |-> decoded.use_file)
    else $error("file op without file operand");

  cov_double: cover property (@(posedge clock) disable iff (!rst_n)
    issue && decoded.is_double);
  cov_skip_dw: cover property (@(posedge clock) disable iff (!rst_n)
    issue && skip_words == 2'h2);
  cov_return: cover property (@(posedge clock) disable iff (!rst_n)
    issue && decoded.opcode == OP_RETFI);
  cov_lone_nop: cover property (@(posedge clock) disable iff (!rst_n)
    issue && decoded.is_nop);

endmodule
`default_nettype wire

// *** tb/ift_fetch_model.sv ***
// partner model: program memory fetch path offering stored words in order
`timescale 1ns/10ps
`default_nettype none
module ift_fetch_model
  import ift_pkg::*;
(
  input  wire logic                  clock,        // instruction clock
  input  wire logic                  rst_n,        // async reset, low active
  input  wire logic                  pc_step,      // word taken at this edge
  input  wire logic [7:0]            prog_len,     // words offered, zero rewinds
  output logic                       fetch_valid,  // word on offer
  output logic [ift_pkg::WORD_W-1:0] fetch_word,   // offered word
  output logic [ift_pkg::WORD_W-1:0] follow_word,  // word after it
  output logic [7:0]                 ptr           // word pointer
);
  logic [WORD_W-1:0] mem [0:15];  // program store, filled by the bench
  logic              took;        // word taken at last rising edge
  logic              tog;         // toggles so idle lines never look stable

  // note a take at the rising edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      took <= 1'b0;
    else
      took <= pc_step;
  end

  // one step per word taken, so a pair advances twice
  always_ff @(negedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr <= 8'h00;
      tog <= 1'b0;
    end
    else
    begin
      tog <= ~tog;
      if (prog_len == 8'h00)
        ptr <= 8'h00;
      else if (took)
        ptr <= ptr + 8'h01;
    end
  end

  // past the end the lines carry a changing pattern, not a stale word
  always_comb
  begin
    fetch_valid = (ptr < prog_len);
    fetch_word  = fetch_valid ? mem[ptr[3:0]] : {12{tog, ~tog}};
    follow_word = (ptr + 8'h01 < prog_len) ? mem[ptr[3:0] + 4'h1] : {12{~tog, tog}};
  end
endmodule
`default_nettype wire

// *** tb/instruction_format_timing_tb.sv ***
// testbench: decode fields, categories and cycle counts of the decoder
`timescale 1ns/10ps
`default_nettype none
module instruction_format_timing_tb;
  import ift_pkg::*;
  logic clock, rst_n, cond_true, fetch_valid, fetch_ready, pc_step, issue, nop_slot;
  logic [WORD_W-1:0] fetch_word, follow_word;
  logic [4:0]        flags_raw;
  logic [7:0]        prog_len, ptr;
  logic [CYC_W-1:0]  cycles;
  logic [1:0]        skip_words;
  ift_dec_t          decoded;
  ift_flags_t        flags;
  ift_dec_t          q_dec [$];  // issued instructions
  logic [1:0]        q_cyc [$];  // their cycle counts
  logic [1:0]        q_skip [$]; // their skip lengths
  logic [23:0]       prog_q [$]; // program for the next run
  int n_errors = 0, n_checks = 0, n_nop = 0, n_stall = 0, n_cyc = 0, n_step = 0;

  ift_decoder DUT (.clock(clock), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .follow_word(follow_word), .cond_true(cond_true),
    .flags_raw(flags_raw), .fetch_ready(fetch_ready), .pc_step(pc_step), .issue(issue),
    .decoded(decoded), .cycles(cycles), .skip_words(skip_words), .nop_slot(nop_slot),
    .flags(flags));
  ift_fetch_model u_mem (.clock(clock), .rst_n(rst_n), .pc_step(pc_step),
    .prog_len(prog_len), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .follow_word(follow_word), .ptr(ptr));

  // ****************************************
  // clock, monitor, timeout
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // collect issues and stall cycles where outputs are settled
  always @(negedge clock)
  begin
    if (rst_n === 1'b1)
    begin
      if (issue === 1'b1)
      begin
        q_dec.push_back(decoded);
        q_cyc.push_back(cycles);
        q_skip.push_back(skip_words);
      end
      if (nop_slot === 1'b1) n_nop++;
      if (fetch_ready === 1'b0) n_stall++;
    end
  end

  // cut a hang short, count words taken at the edge
  always @(posedge clock)
  begin
    n_cyc++;
    if (pc_step === 1'b1) n_step++;
    if (n_cyc == 3000)
    begin
      n_errors++;
      results();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // load prog_q, offer it, wait for all words to be taken and stalls to end
  task automatic run(input logic cond);
    int k;
    q_dec.delete();
    q_cyc.delete();
    q_skip.delete();
    n_nop = 0;
    n_stall = 0;
    n_step = 0;
    for (int i = 0; i < prog_q.size(); i++) u_mem.mem[i] = prog_q[i];
    @(negedge clock);
    cond_true <= cond;
    prog_len  <= 8'(prog_q.size());
    @(negedge clock);
    k = 0;
    while (ptr < 8'(prog_q.size()) && k < 40)
    begin
      @(negedge clock);
      k++;
    end
    repeat (5) @(negedge clock);
    prog_len <= 8'h00;
    @(negedge clock);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_category;
    ift_cat_t exp [7] = '{CAT_WORD, CAT_WORD, CAT_BIT, CAT_LIT, CAT_LIT, CAT_DSP, CAT_CTRL};
    prog_q = {24'h200000, 24'h400000, 24'h600000, 24'h800000, 24'hA00000, 24'hC00000, 24'h0};
    run(1'b0);
    check("issue count", 7, q_cyc.size());
    for (int i = 0; i < q_cyc.size() && i < 7; i++)
    begin
      check("category", 32'(exp[i]), 32'(q_dec[i].category));
      check("cycles", 1, q_cyc[i]);
    end
    check("nop cycles", 0, n_nop);
    $display("category test done");
  endtask

  // fixed multi-cycle ops: returns take three, the rest two
  task automatic t_multi;
    prog_q = {24'h080000, 24'h090000, 24'h0A0000, 24'h0B0000,
              24'h0C0000, 24'h0D0000, 24'h0E0000, 24'h0F0000};
    run(1'b0);
    check("issue count", 8, q_cyc.size());
    for (int i = 0; i < q_cyc.size() && i < 8; i++)
      check("cycles", (i < 6) ? 2 : 3, q_cyc[i]);
    check("nop cycles", 10, n_nop);
    check("stall cycles", 10, n_stall);
    $display("multi-cycle test done");
  endtask

  // conditional branch: one cycle untaken, two taken
  task automatic t_cond;
    prog_q = {24'h100000};
    for (int c = 0; c < 2; c++)
    begin
      run(c[0]);
      check("cond cycles", c + 1, q_cyc.size() ? q_cyc[0] : 2'h0);
      check("cond nop", c, n_nop);
    end
    $display("conditional test done");
  endtask

  // the three pairs, then a lone zero-opcode word
  task automatic t_double;
    prog_q = {24'h021234, 24'h000055, 24'h04ABCD, 24'h00007F, 24'h06BEEF, 24'h000003,
              24'h000042};
    run(1'b0);
    check("issue count", 4, q_cyc.size());
    if (q_cyc.size() == 4)
    begin
      for (int i = 0; i < 3; i++)
      begin
        check("double cycles", 2, q_cyc[i]);
        check("double flag", 1, q_dec[i].is_double);
      end
      check("call addr", 32'h551234, q_dec[0].prog_addr);
      check("goto addr", 32'h7FABCD, q_dec[1].prog_addr);
      check("move literal", 32'hBEEF, q_dec[2].literal);
      check("move dest", 3, q_dec[2].dest_operand_reg);
      check("lone second", 1, q_dec[3].is_nop);
      check("lone single", 0, q_dec[3].is_double);
    end
    check("pair stalls", 0, n_nop);
    check("pc steps", 7, n_step);
    $display("double-word test done");
  endtask

  // skip over single and over double word, and untaken skip
  task automatic t_skip;
    prog_q = {24'hE00000, 24'h200000};
    run(1'b1);
    check("skip1 cycles", 2, q_cyc.size() ? q_cyc[0] : 2'h0);
    check("skip1 words", 1, q_skip.size() ? q_skip[0] : 2'h3);
    prog_q = {24'hE30000, 24'h020000, 24'h000000};
    run(1'b1);
    check("skip2 cycles", 3, q_cyc.size() ? q_cyc[0] : 2'h0);
    check("skip2 words", 2, q_skip.size() ? q_skip[0] : 2'h3);
    run(1'b0);
    check("noskip cycles", 1, q_cyc.size() ? q_cyc[0] : 2'h0);
    $display("skip test done");
  endtask

  // operand fields of each format
  task automatic t_fields;
    prog_q = {24'h21FA5E, 24'h402ABC, 24'h605C00, 24'h80ABC7, 24'hA012F8, 24'h0C0002};
    run(1'b0);
    check("issue count", 6, q_cyc.size());
    if (q_cyc.size() == 6)
    begin
      check("base", 4'hF, q_dec[0].base_operand_reg);
      check("dest", 4'hA, q_dec[0].dest_operand_reg);
      check("dst mode", 1, q_dec[0].dst_mode);
      check("source", 7, q_dec[0].source_operand_reg);
      check("src mode", 2, q_dec[0].src_mode);
      check("file addr", 32'h0ABC, q_dec[1].file_addr);
      check("to reg zero", 1, q_dec[1].to_working_reg_zero);
      check("bit select", 5, q_dec[2].bit_sel);
      check("bit indirect", 1, q_dec[2].bit_indirect);
      check("move literal", 32'h0ABC, q_dec[3].literal);
      check("arith literal", 32'h002F, q_dec[4].literal);
      check("arith dest", 0, q_dec[4].dest_valid);
      check("table mode", 2, q_dec[5].table_mode);
      check("bit file", 1, q_dec[2].use_file);
      check("move dest", 7, q_dec[3].dest_operand_reg);
      check("arith dest reg", 1, q_dec[4].dest_operand_reg);
    end
    $display("field test done");
  endtask

  task automatic t_flags;
    for (int i = 0; i < 2; i++)
    begin
      flags_raw <= i[0] ? 5'h15 : 5'h0A;
      @(negedge clock);
      check("flags", i[0] ? 5'h15 : 5'h0A, flags);
      check("carry", i[0], flags.carry);
      check("digit carry", !i[0], flags.digit_carry);
    end
    $display("flag test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    cond_true = 1'b0;
    flags_raw = 5'h00;
    prog_len = 8'h00;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_category();
    t_multi();
    t_cond();
    t_double();
    t_skip();
    t_fields();
    t_flags();
    results();
  end
endmodule
`default_nettype wire
